// [bench/adcr_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adcr_core_model #(
  parameter int END_DELAY = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_run,
  output logic o_end_proc
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic end_next;
  // keeps pulsing while running so repeat modes see several ends
  // the model only senses the run flag and never drives an analog pin
  always_comb begin
    cnt_next = 8'h00;
    end_next = 1'b0;
    if (i_run) begin
      if (cnt_reg == 8'(END_DELAY - 1)) begin
        end_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      cnt_reg <= 8'h00;
      o_end_proc <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      o_end_proc <= end_next;
    end
  end
endmodule : adcr_core_model
`default_nettype wire

// [bench/adcr_ctrl_regs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module adcr_ctrl_regs_chk #(
  parameter int WAKE_SETTLE_CYC = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [2:0] i_op_mode,
  input wire logic i_end_proc,
  input wire logic o_conv_run,
  input wire logic o_res_10bit,
  input wire logic o_converter_wake,
  input wire logic o_wake_settled,
  input wire logic o_open_wire_assist_on,
  input wire logic o_open_wire_charge_method,
  input wire logic o_ext_access_blocked
);
  logic [7:0] wake_cnt_reg;
  logic [7:0] wake_cnt_next;
  logic wr_run;
  logic rd_run;
  logic [1:0] wd_wake_res;
  assign wr_run = i_ce && i_wr && (i_addr == 16'h00d6) && !o_ext_access_blocked;
  assign rd_run = i_ce && i_rd && (i_addr == 16'h00d6) && !o_ext_access_blocked;
  assign wd_wake_res = i_wdata[5:4];
  always_comb begin
    wake_cnt_next = wake_cnt_reg;
    if (!o_converter_wake) begin
      wake_cnt_next = 8'h00;
    end else if (wake_cnt_reg != 8'hff) begin
      wake_cnt_next = wake_cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      wake_cnt_reg <= 8'h00;
    end else if (i_ce) begin
      wake_cnt_reg <= wake_cnt_next;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  chk_run_start: assert property (wr_run && i_wdata[0] |=> o_conv_run)
    else $error("run flag not set by start write");
  chk_run_stop: assert property (wr_run && !i_wdata[0] |=> !o_conv_run)
    else $error("run flag not cleared by stop write");
  chk_run_read: assert property ($past(rd_run) |-> o_rdata[0] == $past(o_conv_run))
    else $error("run flag read differs from state");
  chk_ctrl0_upper: assert property ($past(rd_run) |-> o_rdata[7:1] == 7'h00)
    else $error("control zero upper bits not zero");
  chk_end_clear: assert property (i_ce && i_end_proc && o_conv_run && !wr_run
    && (i_op_mode == 3'h0 || i_op_mode == 3'h4) |=> !o_conv_run)
    else $error("self ending mode kept running");
  chk_end_keep: assert property (i_ce && i_end_proc && o_conv_run && !wr_run
    && i_op_mode == 3'h2 |=> o_conv_run)
    else $error("repeat mode stopped at end");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_standby_block: assert property (o_ext_access_blocked == !o_converter_wake)
    else $error("access block differs from standby");
  chk_ctrl1_write: assert property (i_ce && i_wr && i_addr == 16'h00d7
    |=> {o_converter_wake, o_res_10bit} == $past(wd_wake_res))
    else $error("wake or resolution not taken from write");
  chk_method_gate: assert property (!o_open_wire_assist_on |-> !o_open_wire_charge_method)
    else $error("charge method active without assist");
  chk_wake_settle: assert property (o_wake_settled |-> wake_cnt_reg >= WAKE_SETTLE_CYC)
    else $error("wake settled too early");
endmodule : adcr_ctrl_regs_chk
`default_nettype wire

// [bench/test_adcr_ctrl_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module test_adcr_ctrl_regs;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic [2:0] i_op_mode = 3'h0;
  logic end_proc;
  logic [7:0] o_rdata;
  logic [7:0] d;
  logic o_conv_run, o_res_10bit, o_converter_wake, o_wake_settled;
  logic o_open_wire_assist_on, o_open_wire_charge_method, o_reference_input_sel, o_ext_access_blocked;
  adcr_pkg::adcr_route_t o_route;
  int bad_count = 0;
  int samples_checked = 0;
  logic [2:0] g0_codes [4] = '{3'h0, 3'h1, 3'h5, 3'h6};
  logic [2:0] modes [3] = '{3'h0, 3'h4, 3'h2};
  always #4 i_clk_sys = ~i_clk_sys;
  adcr_ctrl_regs #(.WAKE_SETTLE_CYC(1)) dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_op_mode(i_op_mode),
    .i_end_proc(end_proc), .o_conv_run(o_conv_run), .o_route(o_route), .o_res_10bit(o_res_10bit),
    .o_converter_wake(o_converter_wake), .o_wake_settled(o_wake_settled),
    .o_open_wire_assist_on(o_open_wire_assist_on), .o_open_wire_charge_method(o_open_wire_charge_method),
    .o_reference_input_sel(o_reference_input_sel), .o_ext_access_blocked(o_ext_access_blocked));
  adcr_core_model #(.END_DELAY(6)) u_core (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_run(o_conv_run),
    .o_end_proc(end_proc));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask : rd
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check({8'h00, v}, {8'h00, exp});
  endtask : rd_chk
  task automatic settle();
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask : settle
  // pin selection only matters when the setting is legal
  task automatic route_chk(input logic [7:0] sel, input logic [11:0] pins, input logic legal);
    wr(16'h00d5, sel);
    settle();
    check({15'h0000, o_route.legal}, {15'h0000, legal});
    if (legal) begin
      check({4'h0, o_route.pin_sel}, {4'h0, pins});
    end
  endtask : route_chk
  task automatic end_test(input string name);
    $display("test done: %s", name);
  endtask : end_test
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    rd_chk(16'h00d5, 8'h00);
    check({15'h0000, o_ext_access_blocked}, 16'h0001);
    rd_chk(16'h00d7, 8'h00);
    wr(16'h00d7, 8'h20);
    settle();
    check({15'h0000, o_wake_settled}, 16'h0001);
    rd_chk(16'h00d5, 8'hc0);
    rd_chk(16'h00d6, 8'h00);
    rd_chk(16'h00e0, 8'h00);
    end_test("reset and standby");
    for (int i = 0; i < 4; i++) route_chk({5'h00, g0_codes[i]}, 12'h001 << g0_codes[i], 1'b1);
    for (int c = 0; c < 4; c++) route_chk({5'h08, 3'(c)}, 12'h100 << c, 1'b1);
    route_chk(8'h02, 12'h000, 1'b0);
    route_chk(8'h44, 12'h000, 1'b0);
    route_chk(8'h80, 12'h000, 1'b0);
    route_chk(8'hc0, 12'h000, 1'b1);
    wr(16'h00d5, 8'h28);
    rd_chk(16'h00d5, 8'h28);
    wr(16'h00d7, 8'h2e);
    rd_chk(16'h00d7, 8'h2e);
    end_test("routing");
    i_op_mode <= 3'h4;
    route_chk(8'h50, 12'hf00, 1'b1);
    route_chk(8'h40, 12'h300, 1'b1);
    route_chk(8'h00, 12'h003, 1'b1);
    wr(16'h00d5, 8'h10);
    rd(16'h00d3, d);
    check({15'h0000, d[1]}, 16'h0001);
    wr(16'h00d5, 8'h40);
    wr(16'h00d7, 8'h21);
    check({15'h0000, o_reference_input_sel}, 16'h0001);
    rd(16'h00d3, d);
    check({15'h0000, d[2]}, 16'h0001);
    i_op_mode <= 3'h0;
    settle();
    rd(16'h00d3, d);
    check({15'h0000, d[3]}, 16'h0001);
    route_chk(8'h00, 12'h000, 1'b1);
    rd(16'h00d3, d);
    check({14'h0000, d[3:2]}, 16'h0000);
    check({15'h0000, o_route.ref_in}, 16'h0001);
    wr(16'h00d5, 8'h01);
    rd(16'h00d3, d);
    check({15'h0000, d[2]}, 16'h0001);
    end_test("sweep and reference");
    wr(16'h00d5, 8'h00);
    wr(16'h00d7, 8'h30);
    check({15'h0000, o_res_10bit}, 16'h0001);
    wr(16'h00d7, 8'ha0);
    check({14'h0000, o_open_wire_assist_on, o_open_wire_charge_method}, 16'h0000);
    wr(16'h00d7, 8'h60);
    wr(16'h00d7, 8'he0);
    check({14'h0000, o_open_wire_assist_on, o_open_wire_charge_method}, 16'h0003);
    i_ce <= 1'b0;
    wr(16'h00d7, 8'h00);
    check({15'h0000, o_converter_wake}, 16'h0001);
    i_ce <= 1'b1;
    wr(16'h00d7, 8'h20);
    end_test("control one fields");
    for (int m = 0; m < 3; m++) begin
      i_op_mode <= modes[m];
      wr(16'h00d5, 8'h00);
      wr(16'h00d6, 8'h01);
      check({15'h0000, o_conv_run}, 16'h0001);
      settle();
      settle();
      settle();
      settle();
      check({15'h0000, o_conv_run}, {15'h0000, modes[m] == 3'h2});
      rd_chk(16'h00d6, {7'h00, modes[m] == 3'h2});
    end
    wr(16'h00d6, 8'hff);
    rd_chk(16'h00d6, 8'h01);
    wr(16'h00d5, 8'h00);
    rd(16'h00d3, d);
    check({15'h0000, d[4]}, 16'h0001);
    wr(16'h00d6, 8'h00);
    rd_chk(16'h00d6, 8'h00);
    wr(16'h00d3, 8'h10);
    rd(16'h00d3, d);
    check({15'h0000, d[4]}, 16'h0000);
    wr(16'h00d6, 8'h01);
    wr(16'h00d7, 8'h20);
    rd(16'h00d3, d);
    check({15'h0000, d[4]}, 16'h0001);
    wr(16'h00d6, 8'h00);
    end_test("conversion");
    wr(16'h00d7, 8'h00);
    check({15'h0000, o_ext_access_blocked}, 16'h0001);
    wr(16'h00d3, 8'h20);
    rd(16'h00d3, d);
    check({15'h0000, d[5]}, 16'h0000);
    wr(16'h00d6, 8'h01);
    settle();
    check({15'h0000, o_conv_run}, 16'h0000);
    rd(16'h00d3, d);
    check({15'h0000, d[5]}, 16'h0001);
    @(posedge i_clk_sys);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    rd_chk(16'h00d7, 8'h00);
    end_test("standby and second reset");
    give_verdict();
  end
endmodule : test_adcr_ctrl_regs
bind adcr_ctrl_regs adcr_ctrl_regs_chk #(.WAKE_SETTLE_CYC(WAKE_SETTLE_CYC)) u_chk (.i_clk_sys(i_clk_sys),
  .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_op_mode(i_op_mode), .i_end_proc(i_end_proc), .o_conv_run(o_conv_run), .o_res_10bit(o_res_10bit),
  .o_converter_wake(o_converter_wake), .o_wake_settled(o_wake_settled),
  .o_open_wire_assist_on(o_open_wire_assist_on), .o_open_wire_charge_method(o_open_wire_charge_method),
  .o_ext_access_blocked(o_ext_access_blocked));
`default_nettype wire

// [hdl/adcr_conv_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module adcr_conv_seq (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_end_proc,
  input wire logic [2:0] i_mode,
  output logic o_running
);
  adcr_pkg::adcr_seq_state_t state_reg, state_next;
  logic self_end;

  // only the modes that finish on their own drop the flag at end processing
  assign self_end = (i_mode == adcr_pkg::ADCR_MODE_ONE_SHOT) || (i_mode == adcr_pkg::ADCR_MODE_SINGLE_SWEEP);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adcr_pkg::ADCR_SEQ_IDLE: begin
        if (i_start) begin
          state_next = adcr_pkg::ADCR_SEQ_RUN;
        end
      end
      adcr_pkg::ADCR_SEQ_RUN: begin
        if (i_stop) begin
          state_next = adcr_pkg::ADCR_SEQ_IDLE;
        end else if (i_end_proc && self_end && !i_start) begin
          state_next = adcr_pkg::ADCR_SEQ_IDLE;
        end
      end
      default: begin
        state_next = adcr_pkg::ADCR_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state_reg <= adcr_pkg::ADCR_SEQ_IDLE;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  // the run state's one-hot bit is the flag itself, so the output leaves a flop directly
  assign o_running = state_reg[1];
endmodule : adcr_conv_seq
`default_nettype wire

// [hdl/adcr_ctrl_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adcr_defines.svh"
module adcr_ctrl_regs #(
  parameter int WAKE_SETTLE_CYC = `ADCR_WAKE_SETTLE_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [2:0] i_op_mode,
  input wire logic i_end_proc,
  output logic o_conv_run,
  output adcr_pkg::adcr_route_t o_route,
  output logic o_res_10bit,
  output logic o_converter_wake,
  output logic o_wake_settled,
  output logic o_open_wire_assist_on,
  output logic o_open_wire_charge_method,
  output logic o_reference_input_sel,
  output logic o_ext_access_blocked
);
  // a zero count could never report settled, so at least one cycle is loaded
  localparam logic [7:0] SETTLE_LOAD = (WAKE_SETTLE_CYC < 1) ? 8'h01 : 8'(WAKE_SETTLE_CYC);

  // register state
  adcr_pkg::adcr_input_sel_t input_sel_reg, input_sel_next;
  logic [7:0] ctrl_one_reg, ctrl_one_next;
  logic [7:0] rdata_reg, rdata_next;

  // status and bookkeeping
  logic wr_in_run_reg, wr_in_run_next;
  logic refused_reg, refused_next;
  logic reselect_reg, reselect_next;
  logic [2:0] mode_seen_reg, mode_seen_next;
  logic [7:0] settle_reg, settle_next;
  logic settled_reg, settled_next;
  logic blocked_out_reg, blocked_out_next;
  logic res_out_reg, res_out_next;
  logic wake_out_reg, wake_out_next;
  logic assist_out_reg, assist_out_next;
  logic method_out_reg, method_out_next;
  logic ref_out_reg, ref_out_next;

  // bus decode
  logic hit_sel;
  logic hit_c0;
  logic hit_c1;
  logic hit_stat;
  logic in_window;
  logic refuse;
  logic wr_ok;
  logic rd_ok;
  logic start_req;
  logic stop_req;
  // converter side
  logic running;
  logic sweep_mode;
  logic mode_legal;
  logic cfg_busy_write;
  logic [7:0] status_word;
  adcr_pkg::adcr_route_t route;

  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  // the status register sits between the two converter windows, so it is never refused
  assign hit_sel = addr_is(i_addr, `ADCR_OFS_INPUT_SEL);
  assign hit_c0 = addr_is(i_addr, `ADCR_OFS_CTRL_ZERO);
  assign hit_c1 = addr_is(i_addr, `ADCR_OFS_CTRL_ONE);
  assign hit_stat = addr_is(i_addr, `ADCR_OFS_CFG_STATUS);

  // control one stays reachable in standby, otherwise the part could never wake
  assign in_window = adcr_pkg::adcr_in_range(i_addr, `ADCR_BLK_A_LO, `ADCR_BLK_A_HI) ||
                     adcr_pkg::adcr_in_range(i_addr, `ADCR_BLK_B_LO, `ADCR_BLK_B_HI);
  assign refuse = !ctrl_one_reg[`ADCR_WAKE_BIT] && in_window && !hit_c1;
  assign wr_ok = i_wr && !refuse;
  assign rd_ok = i_rd && !refuse;

  assign start_req = wr_ok && hit_c0 && i_wdata[`ADCR_RUN_BIT];
  assign stop_req = wr_ok && hit_c0 && !i_wdata[`ADCR_RUN_BIT];

  // mode code check
  always_comb begin
    mode_legal = 1'b0;
    sweep_mode = 1'b0;
    case (i_op_mode)
      adcr_pkg::ADCR_MODE_ONE_SHOT: mode_legal = 1'b1;
      adcr_pkg::ADCR_MODE_REPEAT0: mode_legal = 1'b1;
      adcr_pkg::ADCR_MODE_REPEAT1: mode_legal = 1'b1;
      adcr_pkg::ADCR_MODE_SINGLE_SWEEP: begin
        mode_legal = 1'b1;
        sweep_mode = 1'b1;
      end
      adcr_pkg::ADCR_MODE_REPEAT_SWEEP: begin
        mode_legal = 1'b1;
        sweep_mode = 1'b1;
      end
      // unlisted codes are illegal and never count as a sweep
      default: begin
        mode_legal = 1'b0;
        sweep_mode = 1'b0;
      end
    endcase
  end

  // start and stop come only from accepted writes, so a refused start never runs
  adcr_conv_seq u_seq (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_start(start_req),
    .i_stop(stop_req),
    .i_end_proc(i_end_proc),
    .i_mode(i_op_mode),
    .o_running(running)
  );

  // routing is registered, so the input mux follows a write one cycle later
  adcr_input_route u_route (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_sel(input_sel_reg),
    .i_ref_sel(ctrl_one_reg[`ADCR_REF_BIT]),
    .i_sweep_mode(sweep_mode),
    .o_route(route)
  );

  // register writes; reserved bits are kept as written
  // a refused write leaves every register but the refused flag as it was
  always_comb begin
    input_sel_next = input_sel_reg;
    ctrl_one_next = ctrl_one_reg;
    if (wr_ok && hit_sel) begin
      input_sel_next = adcr_pkg::adcr_input_sel_t'(i_wdata);
    end
    if (wr_ok && hit_c1) begin
      ctrl_one_next = i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      input_sel_reg <= adcr_pkg::adcr_input_sel_t'(`ADCR_INPUT_SEL_RST);
      ctrl_one_reg <= `ADCR_CTRL_ONE_RST;
    end else if (i_ce) begin
      input_sel_reg <= input_sel_next;
      ctrl_one_reg <= ctrl_one_next;
    end
  end

  // the result of a reconfigured conversion is undefined; the hazard is only flagged, never blocked
  assign cfg_busy_write = wr_ok && running && (hit_sel || hit_c1);

  // sticky flags, write one to clear; a new event beats the clear
  always_comb begin
    wr_in_run_next = wr_in_run_reg;
    refused_next = refused_reg;
    if (wr_ok && hit_stat && i_wdata[`ADCR_ST_WR_IN_RUN]) begin
      wr_in_run_next = 1'b0;
    end
    if (wr_ok && hit_stat && i_wdata[`ADCR_ST_REFUSED]) begin
      refused_next = 1'b0;
    end
    if (cfg_busy_write) begin
      wr_in_run_next = 1'b1;
    end
    if ((i_wr || i_rd) && refuse) begin
      refused_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      wr_in_run_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else if (i_ce) begin
      wr_in_run_reg <= wr_in_run_next;
      refused_reg <= refused_next;
    end
  end

  // a mode change leaves the channel choice stale until software writes it again
  always_comb begin
    mode_seen_next = i_op_mode;
    reselect_next = reselect_reg;
    if (i_op_mode != mode_seen_reg) begin
      reselect_next = 1'b1;
    end else if (wr_ok && hit_sel) begin
      reselect_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      mode_seen_reg <= 3'h0;
      reselect_reg <= 1'b0;
    end else if (i_ce) begin
      mode_seen_reg <= mode_seen_next;
      reselect_reg <= reselect_next;
    end
  end

  // wake settle timer: the start is not held off, only reported
  always_comb begin
    settle_next = settle_reg;
    settled_next = settled_reg;
    if (!ctrl_one_next[`ADCR_WAKE_BIT]) begin
      settle_next = 8'h00;
      settled_next = 1'b0;
    end else if (!ctrl_one_reg[`ADCR_WAKE_BIT]) begin
      settle_next = SETTLE_LOAD;
      settled_next = 1'b0;
    end else if (settle_reg != 8'h00) begin
      settle_next = settle_reg - 8'h01;
      settled_next = (settle_reg == 8'h01);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      settle_reg <= 8'h00;
      settled_reg <= 1'b0;
    end else if (i_ce) begin
      settle_reg <= settle_next;
      settled_reg <= settled_next;
    end
  end

  // registered copies of the control outputs
  // the analog side sees flops only, never decode glitches
  always_comb begin
    blocked_out_next = !ctrl_one_next[`ADCR_WAKE_BIT];
    res_out_next = ctrl_one_next[`ADCR_RES_BIT];
    wake_out_next = ctrl_one_next[`ADCR_WAKE_BIT];
    assist_out_next = ctrl_one_next[`ADCR_ASSIST_BIT];
    // method only takes effect once the assist is enabled
    method_out_next = ctrl_one_next[`ADCR_ASSIST_BIT] & ctrl_one_next[`ADCR_CHARGE_BIT];
    ref_out_next = ctrl_one_next[`ADCR_REF_BIT];
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      blocked_out_reg <= 1'b1;
      res_out_reg <= 1'b0;
      wake_out_reg <= 1'b0;
      assist_out_reg <= 1'b0;
      method_out_reg <= 1'b0;
      ref_out_reg <= 1'b0;
    end else if (i_ce) begin
      blocked_out_reg <= blocked_out_next;
      res_out_reg <= res_out_next;
      wake_out_reg <= wake_out_next;
      assist_out_reg <= assist_out_next;
      method_out_reg <= method_out_next;
      ref_out_reg <= ref_out_next;
    end
  end

  // status view
  // these bits only report; none of them holds off a conversion
  always_comb begin
    status_word = 8'h00;
    status_word[`ADCR_ST_ROUTE_BAD] = !route.legal || !mode_legal;
    status_word[`ADCR_ST_SWEEP_GRP] = input_sel_reg.sweep_length_sel &&
                                      (input_sel_reg.group_sel != adcr_pkg::ADCR_GRP_ONE);
    status_word[`ADCR_ST_REF_CONFLICT] = ctrl_one_reg[`ADCR_REF_BIT] &&
                                         (sweep_mode || input_sel_reg.channel_code != 3'h0 ||
                                          ctrl_one_reg[`ADCR_ASSIST_BIT]);
    status_word[`ADCR_ST_RESELECT] = reselect_reg;
    status_word[`ADCR_ST_WR_IN_RUN] = wr_in_run_reg;
    status_word[`ADCR_ST_REFUSED] = refused_reg;
    status_word[`ADCR_ST_WAKE_OK] = settled_reg;
  end

  // read data stand for exactly one cycle; refused or unmapped reads return zero
  always_comb begin
    rdata_next = 8'h00;
    if (rd_ok) begin
      if (hit_sel) begin
        rdata_next = input_sel_reg;
      end else if (hit_c0) begin
        rdata_next = {7'h00, running};
      end else if (hit_c1) begin
        rdata_next = ctrl_one_reg;
      end else if (hit_stat) begin
        rdata_next = status_word;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      rdata_reg <= 8'h00;
    end else if (i_ce) begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_conv_run = running;
  assign o_route = route;
  assign o_res_10bit = res_out_reg;
  assign o_converter_wake = wake_out_reg;
  assign o_wake_settled = settled_reg;
  assign o_open_wire_assist_on = assist_out_reg;
  assign o_open_wire_charge_method = method_out_reg;
  assign o_reference_input_sel = ref_out_reg;
  assign o_ext_access_blocked = blocked_out_reg;
endmodule : adcr_ctrl_regs
`default_nettype wire

// [hdl/adcr_defines.svh]
`ifndef ADCR_DEFINES_SVH
`define ADCR_DEFINES_SVH

// register offsets
`define ADCR_OFS_CFG_STATUS 16'h00d3
`define ADCR_OFS_INPUT_SEL 16'h00d5
`define ADCR_OFS_CTRL_ZERO 16'h00d6
`define ADCR_OFS_CTRL_ONE 16'h00d7

// converter address windows closed during standby, except control one at 16'h00d7
`define ADCR_BLK_A_LO 16'h00c0
`define ADCR_BLK_A_HI 16'h00cf
`define ADCR_BLK_B_LO 16'h00d4
`define ADCR_BLK_B_HI 16'h00d7

// input_select_reg fields
`define ADCR_CH_LSB 0
`define ADCR_CH_MSB 2
`define ADCR_SWEEP_BIT 4
`define ADCR_GRP_LSB 6
`define ADCR_GRP_MSB 7

// control_zero_reg / control_one_reg fields
`define ADCR_RUN_BIT 0
`define ADCR_REF_BIT 0
`define ADCR_RES_BIT 4
`define ADCR_WAKE_BIT 5
`define ADCR_ASSIST_BIT 6
`define ADCR_CHARGE_BIT 7

// status register fields
`define ADCR_ST_ROUTE_BAD 0
`define ADCR_ST_SWEEP_GRP 1
`define ADCR_ST_REF_CONFLICT 2
`define ADCR_ST_RESELECT 3
`define ADCR_ST_WR_IN_RUN 4
`define ADCR_ST_REFUSED 5
`define ADCR_ST_WAKE_OK 6

// reset values
`define ADCR_INPUT_SEL_RST 8'hc0
`define ADCR_CTRL_ZERO_RST 8'h00
`define ADCR_CTRL_ONE_RST 8'h00

// timing
`define ADCR_CLK_PERIOD_PS 8000
`define ADCR_WAKE_SETTLE_NS 32
`define ADCR_WAKE_SETTLE_CYC ((`ADCR_WAKE_SETTLE_NS * 1000 + `ADCR_CLK_PERIOD_PS - 1) / `ADCR_CLK_PERIOD_PS)

`endif

// [hdl/adcr_input_route.sv]
`timescale 1ns/1ps
`default_nettype none
module adcr_input_route (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire adcr_pkg::adcr_input_sel_t i_sel,
  input wire logic i_ref_sel,
  input wire logic i_sweep_mode,
  output adcr_pkg::adcr_route_t o_route
);
  adcr_pkg::adcr_route_t route_reg, route_next;

  always_comb begin
    route_next = '0;
    if (i_ref_sel) begin
      route_next.ref_in = 1'b1;
      route_next.legal = (i_sel.channel_code == 3'h0) && !i_sweep_mode;
    end else if (i_sweep_mode) begin
      case (i_sel.group_sel)
        adcr_pkg::ADCR_GRP_ZERO: begin
          route_next.pin_sel = 12'h003;
          route_next.legal = !i_sel.sweep_length_sel;
        end
        adcr_pkg::ADCR_GRP_ONE: begin
          route_next.pin_sel = i_sel.sweep_length_sel ? 12'hf00 : 12'h300;
          route_next.legal = 1'b1;
        end
        default: begin
          route_next.legal = 1'b0;
        end
      endcase
    end else begin
      case (i_sel.group_sel)
        adcr_pkg::ADCR_GRP_ZERO: begin
          case (i_sel.channel_code)
            3'h0: route_next.pin_sel = 12'h001;
            3'h1: route_next.pin_sel = 12'h002;
            3'h5: route_next.pin_sel = 12'h020;
            3'h6: route_next.pin_sel = 12'h040;
            default: route_next.pin_sel = 12'h000;
          endcase
          route_next.legal = (route_next.pin_sel != 12'h000);
        end
        adcr_pkg::ADCR_GRP_ONE: begin
          if (!i_sel.channel_code[2]) begin
            route_next.pin_sel = 12'h100 << i_sel.channel_code[1:0];
            route_next.legal = 1'b1;
          end
        end
        adcr_pkg::ADCR_GRP_NONE: begin
          route_next.legal = 1'b1;
        end
        default: begin
          route_next.legal = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      route_reg <= '0;
    end else if (i_ce) begin
      route_reg <= route_next;
    end
  end

  assign o_route = route_reg;
endmodule : adcr_input_route
`default_nettype wire

// [hdl/adcr_pkg.sv]
package adcr_pkg;

  typedef enum logic [2:0] {
    ADCR_MODE_ONE_SHOT = 3'h0,
    ADCR_MODE_REPEAT0 = 3'h2,
    ADCR_MODE_REPEAT1 = 3'h3,
    ADCR_MODE_SINGLE_SWEEP = 3'h4,
    ADCR_MODE_REPEAT_SWEEP = 3'h6
  } adcr_mode_t;

  typedef enum logic [1:0] {
    ADCR_GRP_ZERO = 2'h0,
    ADCR_GRP_ONE = 2'h1,
    ADCR_GRP_BAD = 2'h2,
    ADCR_GRP_NONE = 2'h3
  } adcr_group_t;

  typedef enum logic [1:0] {
    ADCR_SEQ_IDLE = 2'b01,
    ADCR_SEQ_RUN = 2'b10
  } adcr_seq_state_t;

  typedef struct packed {
    logic [1:0] group_sel;
    logic rsv5;
    logic sweep_length_sel;
    logic rsv3;
    logic [2:0] channel_code;
  } adcr_input_sel_t;

  typedef struct packed {
    logic [11:0] pin_sel;
    logic ref_in;
    logic legal;
  } adcr_route_t;

  function automatic logic adcr_in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    adcr_in_range = (a >= lo) && (a <= hi);
  endfunction : adcr_in_range

endpackage : adcr_pkg
